// ---- design/nsx_pkg.sv ----
package nsx_pkg;

  // ==========================================================
  // Widths
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DIR_COUNT = 3;

  // ==========================================================
  // Opcode fields, bits 13:8 unless noted
  localparam logic [5:0] OPC_SWAP = 6'h0e;
  localparam logic [5:0] OPC_XOR_LIT = 6'h3a;
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  // Bits 13:7 of the store-working-register move
  localparam logic [6:0] OPC_MOVE_W = 7'h01;
  // Bits 13:3 of the direction load
  localparam logic [10:0] OPC_DIR_LOAD = 11'h00c;
  localparam logic [2:0] DIR_SEL_MIN = 3'h5;
  localparam logic [2:0] DIR_SEL_MAX = 3'h7;

  // ==========================================================
  // Field positions
  localparam int DEST_BIT = 7;
  localparam int OPC_LSB = 8;

  // ==========================================================
  // File address map of the direction registers
  localparam logic [ADDR_W-1:0] DIR_FILE_BASE = 7'h05;

  // ==========================================================
  // Reset values
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } nsx_phase_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SWAP,
    OP_XOR_LIT,
    OP_XOR_FILE,
    OP_DIR_LOAD,
    OP_MOVE_W,
    OP_MOVE_FILE
  } nsx_op_t;

  typedef struct packed {
    nsx_op_t op;
    logic to_file;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
  } nsx_dec_t;

  typedef struct packed {
    logic [DATA_W-1:0] dir7;
    logic [DATA_W-1:0] dir6;
    logic [DATA_W-1:0] dir5;
  } nsx_dir_t;

endpackage

// ---- design/nsx_file_ram.sv ----
`timescale 1ns/1ps
module nsx_file_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock
  input wire logic i_sys_clk,
  // Read port
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data,
  // Write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Read data registered; old data on same-address collision
  always_ff @(posedge i_sys_clk) begin
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// ---- design/nsx_exec.sv ----
`timescale 1ns/1ps
module nsx_exec
  import nsx_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Instruction from fetch, taken in phase Q1
  input wire logic i_instr_valid,
  input wire logic [nsx_pkg::INSTR_W-1:0] i_instr,
  // Architectural state
  output logic [nsx_pkg::DATA_W-1:0] o_w,
  output logic o_zero,
  output nsx_pkg::nsx_dir_t o_dir,
  // Sequencing
  output logic o_cycle_start,
  output logic o_done,
  output logic o_illegal
);
  import nsx_pkg::*;

  // ==========================================================
  // Phase counter
  nsx_phase_t phase;
  nsx_phase_t next_phase;

  always_comb begin
    unique case (phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: next_phase = PH_Q1;
    endcase
  end

  // Free running so fetch never waits on this block
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // ==========================================================
  // Decode
  nsx_dec_t next_dec;
  nsx_dec_t dec;
  logic next_bad;

  always_comb begin
    next_dec.op = OP_NONE;
    next_dec.to_file = i_instr[DEST_BIT];
    next_dec.addr = i_instr[ADDR_W-1:0];
    next_dec.lit = i_instr[DATA_W-1:0];
    next_bad = 1'b0;
    if (!i_instr_valid) begin
      next_dec.op = OP_NONE;
    end else if (i_instr[13:OPC_LSB] == OPC_SWAP) begin
      next_dec.op = OP_SWAP;
    end else if (i_instr[13:OPC_LSB] == OPC_XOR_LIT) begin
      next_dec.op = OP_XOR_LIT;
    end else if (i_instr[13:OPC_LSB] == OPC_XOR_FILE) begin
      next_dec.op = OP_XOR_FILE;
    end else if (i_instr[13:OPC_LSB] == OPC_MOVE_FILE) begin
      next_dec.op = OP_MOVE_FILE;
    end else if (i_instr[13:7] == OPC_MOVE_W) begin
      next_dec.op = OP_MOVE_W;
      next_dec.to_file = 1'b1;
    end else if (i_instr[13:3] == OPC_DIR_LOAD) begin
      // Operand 0 to 4 has no direction register behind it
      if (i_instr[2:0] >= DIR_SEL_MIN && i_instr[2:0] <= DIR_SEL_MAX) begin
        next_dec.op = OP_DIR_LOAD;
      end else begin
        next_bad = 1'b1;
      end
    end else begin
      next_bad = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dec <= '0;
    end else if (phase == PH_Q1) begin
      dec <= next_dec;
    end
  end

  // ==========================================================
  // File operand read
  logic dir_hit_rd;
  logic [1:0] dir_idx_rd;
  logic [DATA_W-1:0] ram_rd_data;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] dir_q [DIR_COUNT];

  always_comb begin
    dir_hit_rd = (dec.addr >= DIR_FILE_BASE) &&
                 (dec.addr < DIR_FILE_BASE + ADDR_W'(DIR_COUNT));
    dir_idx_rd = 2'(dec.addr - DIR_FILE_BASE);
  end

  // Operand is picked in Q2 once the memory read data has settled
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      operand <= '0;
    end else if (phase == PH_Q2) begin
      operand <= dir_hit_rd ? dir_q[dir_idx_rd] : ram_rd_data;
    end
  end

  // ==========================================================
  // Compute in Q3
  logic [DATA_W-1:0] next_result;
  logic [DATA_W-1:0] result;
  logic result_to_file;
  logic next_to_file;

  always_comb begin
    next_result = operand;
    next_to_file = dec.to_file;
    unique case (dec.op)
      OP_SWAP: next_result = {operand[3:0], operand[7:4]};
      OP_XOR_LIT: begin
        next_result = o_w ^ dec.lit;
        next_to_file = 1'b0;
      end
      OP_XOR_FILE: next_result = o_w ^ operand;
      OP_DIR_LOAD: next_result = o_w;
      OP_MOVE_W: next_result = o_w;
      OP_MOVE_FILE: next_result = operand;
      OP_NONE: next_result = operand;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result <= '0;
      result_to_file <= 1'b0;
    end else if (phase == PH_Q3) begin
      result <= next_result;
      result_to_file <= next_to_file;
    end
  end

  // ==========================================================
  // Write back in Q4
  logic wb;
  logic wr_w;
  logic wr_file;
  logic ram_wr_en;
  logic sets_zero;

  always_comb begin
    wb = (phase == PH_Q4) && (dec.op != OP_NONE);
    wr_w = wb && (dec.op != OP_DIR_LOAD) && !result_to_file;
    wr_file = wb && (dec.op != OP_DIR_LOAD) && result_to_file;
    ram_wr_en = wr_file && !dir_hit_rd;
    sets_zero = wb && (dec.op == OP_XOR_LIT || dec.op == OP_XOR_FILE ||
                       dec.op == OP_MOVE_FILE);
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_w <= W_RESET;
    end else if (wr_w) begin
      o_w <= result;
    end
  end

  // Swap and direction load never touch this flag
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_zero <= 1'b0;
    end else if (sets_zero) begin
      o_zero <= (result == '0);
    end
  end

  genvar g;
  generate
    for (g = 0; g < DIR_COUNT; g++) begin : g_dir
      logic load_hit;
      logic file_hit;
      assign load_hit = wb && (dec.op == OP_DIR_LOAD) &&
                        (dec.addr[2:0] == DIR_SEL_MIN + 3'(g));
      assign file_hit = wr_file && dir_hit_rd && (dir_idx_rd == 2'(g));
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          dir_q[g] <= DIR_RESET;
        end else if (load_hit || file_hit) begin
          dir_q[g] <= result;
        end
      end
    end
  endgenerate

  assign o_dir = '{dir7: dir_q[2], dir6: dir_q[1], dir5: dir_q[0]};

  // ==========================================================
  // Sequencing flags
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cycle_start <= 1'b0;
      o_done <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      o_cycle_start <= (next_phase == PH_Q1);
      o_done <= wb;
      o_illegal <= (phase == PH_Q1) && next_bad;
    end
  end

  // ==========================================================
  // General file registers
  nsx_file_ram #(
    .WIDTH(DATA_W),
    .DEPTH(FILE_DEPTH),
    .AW(ADDR_W)
  ) u_file_ram (
    .i_sys_clk(i_sys_clk),
    .i_rd_en(phase == PH_Q1),
    .i_rd_addr(i_instr[ADDR_W-1:0]),
    .o_rd_data(ram_rd_data),
    .i_wr_en(ram_wr_en),
    .i_wr_addr(dec.addr),
    .i_wr_data(result)
  );

endmodule

// ---- test/nsx_exec_assertions.sv ----
`timescale 1ns/1ps
module nsx_exec_chk
  import nsx_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Instruction
  input wire logic i_instr_valid,
  input wire logic [nsx_pkg::INSTR_W-1:0] i_instr,
  // State
  input wire logic [nsx_pkg::DATA_W-1:0] o_w,
  input wire logic o_zero,
  input wire nsx_pkg::nsx_dir_t o_dir,
  // Sequencing
  input wire logic o_cycle_start,
  input wire logic o_done,
  input wire logic o_illegal
);
  import nsx_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic take;
  logic [7:0] lit;
  assign take = o_cycle_start && i_instr_valid;
  assign lit = i_instr[7:0];
  a_cycle_period: assert property (o_cycle_start |=> !o_cycle_start [*3] ##1 o_cycle_start)
    else $error("cycle start period wrong");
  a_done_at_start: assert property (o_done |-> o_cycle_start)
    else $error("done off cycle boundary");
  a_w_on_done: assert property ($changed(o_w) |-> o_done)
    else $error("w changed without done");
  a_dir_on_done: assert property ($changed(o_dir) |-> o_done)
    else $error("direction changed without done");
  a_xorlit_result: assert property (take && i_instr[13:8] == OPC_XOR_LIT |-> ##4 o_done &&
    o_w == ($past(o_w, 4) ^ $past(lit, 4)) && o_zero == (o_w == 8'h00))
    else $error("literal xor result wrong");
  a_swap_flag: assert property (
    take && i_instr[13:8] == OPC_SWAP |-> ##4 o_done && $stable(o_zero))
    else $error("swap touched zero");
  a_xorfile_dest: assert property (take && i_instr[13:7] == {OPC_XOR_FILE, 1'b1} |->
    ##4 o_done && $stable(o_w))
    else $error("file xor wrote w");
  a_dirload_flag: assert property (
    take && i_instr[13:3] == OPC_DIR_LOAD && i_instr[2:0] >= DIR_SEL_MIN
    |-> ##4 o_done && $stable(o_zero) && $stable(o_w))
    else $error("direction load touched w or zero");
  // Illegal pulse stands one clock right after the taking edge
  a_dirload_bad: assert property (
    take && i_instr[13:3] == OPC_DIR_LOAD && i_instr[2:0] < DIR_SEL_MIN
    |-> ##1 o_illegal ##3 !o_done && $stable(o_dir))
    else $error("bad direction operand accepted");
endmodule
bind nsx_exec nsx_exec_chk i_chk (.i_sys_clk, .i_reset_n, .i_instr_valid, .i_instr, .o_w, .o_zero,
  .o_dir, .o_cycle_start, .o_done, .o_illegal);

// ---- test/nibble_swap_xor_direction_load_op_exec_test.sv ----
`timescale 1ns/1ps
module nibble_swap_xor_direction_load_op_exec_test;
  import nsx_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_instr_valid = 1'b0;
  logic [INSTR_W-1:0] i_instr = 14'h0000;
  logic [DATA_W-1:0] o_w;
  logic o_zero;
  nsx_dir_t o_dir;
  logic o_cycle_start;
  logic o_done;
  logic o_illegal;
  // ==========================================================
  // Models of W, zero and direction registers
  logic [7:0] mw = 8'h00;
  logic mz = 1'b0;
  logic [23:0] md = 24'hffffff;
  int fail_count = 0;
  int cmp_count = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  nsx_exec i_dut (.i_sys_clk, .i_reset_n, .i_instr_valid, .i_instr, .o_w, .o_zero, .o_dir,
    .o_cycle_start, .o_done, .o_illegal);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One full instruction cycle; caller updates the models first
  task automatic run(input logic [13:0] ins, input logic vld, input logic ill);
    i_instr = ins;
    i_instr_valid = vld;
    // Illegal pulse stands only in the clock after the taking edge
    @(posedge i_sys_clk);
    #10;
    chk(24'(o_illegal), 24'(ill));
    repeat (3) @(posedge i_sys_clk);
    #10;
    chk(24'(o_done), 24'(vld & ~ill));
    chk(24'(o_cycle_start), 24'h1);
    chk(24'(o_w), 24'(mw));
    chk(24'(o_zero), 24'(mz));
    chk(o_dir, md);
  endtask
  task automatic xl(input logic [7:0] k);
    mw = mw ^ k;
    mz = (mw == 8'h00);
    run({OPC_XOR_LIT, k}, 1'b1, 1'b0);
  endtask
  task automatic stw(input logic [6:0] f);
    run({OPC_MOVE_W, f}, 1'b1, 1'b0);
  endtask
  task automatic t_lit;
    xl(8'hb5);
    xl(8'haf);
    chk(24'(o_w), 24'h1a);
    xl(8'h1a);
    $display("t_lit done");
  endtask
  task automatic t_swap;
    xl(mw ^ 8'ha5);
    stw(7'h20);
    xl(8'ha5);
    mw = 8'h5a;
    run({OPC_SWAP, 1'b0, 7'h20}, 1'b1, 1'b0);
    run({OPC_SWAP, 1'b1, 7'h20}, 1'b1, 1'b0);
    mw = 8'ha5;
    run({OPC_SWAP, 1'b0, 7'h20}, 1'b1, 1'b0);
    $display("t_swap done");
  endtask
  task automatic t_xorf;
    xl(mw ^ 8'hb5);
    stw(7'h21);
    mz = 1'b1;
    run({OPC_XOR_FILE, 1'b1, 7'h21}, 1'b1, 1'b0);
    mz = 1'b0;
    run({OPC_XOR_FILE, 1'b0, 7'h21}, 1'b1, 1'b0);
    $display("t_xorf done");
  endtask
  task automatic t_dir;
    for (int f = 0; f < 8; f++) begin
      xl(mw ^ (8'h10 + 8'(f)));
      if (f >= 5) begin
        md[(f - 5) * 8 +: 8] = mw;
      end
      run({OPC_DIR_LOAD, 3'(f)}, 1'b1, 1'(f < 5));
    end
    $display("t_dir done");
  endtask
  task automatic t_dfile;
    xl(mw ^ 8'h3c);
    md[15:8] = 8'h3c;
    stw(7'h06);
    xl(8'h3c);
    mw = {md[19:16], md[23:20]};
    run({OPC_SWAP, 1'b0, 7'h07}, 1'b1, 1'b0);
    // Plain file move reads a direction register into W and clears zero
    mw = md[15:8];
    mz = 1'b0;
    run({OPC_MOVE_FILE, 1'b0, 7'h06}, 1'b1, 1'b0);
    $display("t_dfile done");
  endtask
  task automatic t_bad;
    run(14'h3e00, 1'b1, 1'b1);
    run({OPC_XOR_LIT, 8'h55}, 1'b0, 1'b0);
    $display("t_bad done");
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    #10;
    i_reset_n = 1'b1;
    t_lit;
    t_swap;
    t_xorf;
    t_dir;
    t_dfile;
    t_bad;
    stop_test;
  end
  // Roughly 35 instruction cycles expected; allow ample margin
  initial begin
    #60000;
    fail_count++;
    stop_test;
  end
endmodule
